// [core/mclk_source_select.sv]
// master clock source selector with apb control registers
`timescale 1ns/1ps
`include "mclk_sel_params.svh"

module mclk_source_select
  import mclk_sel_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                   REF_CLK,           // 20 MHz reference clock
  input  wire logic                   RST,               // async power-on reset, high
  input  wire logic                   PSEL,              // apb select
  input  wire logic                   PENABLE,           // apb access phase
  input  wire logic                   PWRITE,            // apb direction
  input  wire logic [ADDR_W-1:0]      PADDR,             // apb byte address
  input  wire logic [31:0]            PWDATA,            // apb write data
  output logic      [31:0]            PRDATA,            // apb read data
  output logic                        PREADY,            // apb ready
  output logic                        PSLVERR,           // apb error
  input  wire logic                   CLOCK_SOURCE_SELECT, // high crystal, low bit clock
  input  wire logic                   MASTER_RATIO_HI,   // ratio code bit 1
  input  wire logic                   MASTER_RATIO_LO,   // ratio code bit 0
  input  wire logic                   MASTER_SLAVE_SELECT, // high master, low slave
  input  wire logic                   EEPROM_PORT_SELECT, // selects shared clock pins
  input  wire logic                   INITIAL_RESET_N,   // initial reset, low
  input  wire logic                   SYSTEM_RESET_N,    // system reset, low
  input  wire logic                   CLOCK_RESET_PIN_N, // clock reset pin, low
  input  wire logic                   FRAME_CLOCK_IN,    // slave frame clock
  input  wire logic                   BIT_CLOCK_IN,      // slave bit clock
  input  wire logic                   BIT_CLOCK,         // shared bit clock pin, input side
  output logic                        FRAME_CLOCK_OUT,   // forwarded frame clock
  output logic                        BIT_CLOCK_OUT,     // forwarded bit clock
  output logic                        CLOCKS_HELD,       // internal clocks in reset
  output logic                        PLL_ENABLE,        // pll in use
  output mclk_sel_pkg::ref_sel_t      PLL_REF_SEL,       // pll reference
  output logic      [6:0]             PLL_MULT_NUM,      // multiply numerator
  output logic      [1:0]             PLL_MULT_DEN,      // multiply denominator
  output logic      [2:0]             SAMPLE_MODE,       // effective sample mode
  output logic                        CONFIG_VALID,      // selection has a clock
  output logic                        PHASE_ALIGN,       // one-cycle slave alignment pulse
  output logic                        ADC_POWER_SAVE,    // adc power save
  output logic                        CODEC_POWER_SAVE   // codec power save
);

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  ctl_state_t  state_q;
  logic [7:0]  rate_cfg_q;
  logic [1:0]  power_q;
  logic [2:0]  clk_out_q;
  logic        cap_src_q;
  logic [1:0]  cap_code_q;
  logic        cap_master_q;
  logic        cap_ee_q;
  logic        hold_d;
  logic        release_q;
  logic        sys_rise_q;
  logic        slave_bck_d;
  logic        sel_bck_q;
  logic        apb_acc;
  logic        apb_wr;
  logic        map_hit;
  logic        wr_denied;
  logic [7:0]  offs;
  logic [31:0] rdata_d;

  assign offs    = PADDR[7:0];
  assign apb_acc = PSEL & PENABLE;
  assign apb_wr  = apb_acc & PWRITE;
  assign map_hit = (offs == `RATE_CFG_OFS) | (offs == `POWER_CTRL_OFS) |
                   (offs == `CLOCK_OUT_OFS) | (offs == `CLOCK_STATUS_OFS) |
                   (offs == `MCLK_NOMINAL_OFS);
  // rate config accepts writes only while system reset holds the core
  assign wr_denied = PWRITE & (offs == `RATE_CFG_OFS) & SYSTEM_RESET_N;

  // clock reset from initial reset, the pin or the register bit
  assign hold_d = ~INITIAL_RESET_N | ~CLOCK_RESET_PIN_N | rate_cfg_q[`CLK_RST_BIT_POS];

  // software registers, cleared by initial reset too
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rate_cfg_q <= `RATE_CFG_RST;
      power_q    <= `POWER_CTRL_RST;
      clk_out_q  <= `CLOCK_OUT_RST;
    end else if (!INITIAL_RESET_N) begin
      rate_cfg_q <= `RATE_CFG_RST;
      power_q    <= `POWER_CTRL_RST;
      clk_out_q  <= `CLOCK_OUT_RST;
    end else if (apb_wr && !wr_denied) begin
      case (offs)
        `RATE_CFG_OFS:   rate_cfg_q <= {PWDATA[7:1], 1'b0};
        `POWER_CTRL_OFS: power_q    <= PWDATA[1:0];
        `CLOCK_OUT_OFS:  clk_out_q  <= {PWDATA[`FAMILY_44K_POS], PWDATA[1:0]};
        default:         rate_cfg_q <= rate_cfg_q;
      endcase
    end
  end

  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (offs)
      `RATE_CFG_OFS:     rdata_d = {24'h00_0000, rate_cfg_q};
      `POWER_CTRL_OFS:   rdata_d = {30'h000_0000, power_q};
      `CLOCK_OUT_OFS:    rdata_d = {27'h00_0000, clk_out_q[2], 2'h0, clk_out_q[1:0]};
      `CLOCK_STATUS_OFS: rdata_d = {19'h0000, sel_bck_q, SAMPLE_MODE, CONFIG_VALID, CLOCKS_HELD,
                                    PLL_ENABLE, PLL_REF_SEL, cap_ee_q, cap_master_q,
                                    cap_src_q, cap_code_q[0]};
      `MCLK_NOMINAL_OFS: rdata_d = clk_out_q[2] ? `MCLK_NOM_44K_HZ : `MCLK_NOM_48K_HZ;
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // apb answer: zero wait states, error on unmapped or refused access
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & (~map_hit | wr_denied);
      PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rdata_d : 32'h0000_0000;
    end
  end

  // pins track only while the clock reset holds; open ratio pins pull low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cap_src_q    <= 1'b1;
      cap_code_q   <= 2'h0;
      cap_master_q <= 1'b0;
      cap_ee_q     <= 1'b0;
    end else if (hold_d) begin
      cap_src_q    <= CLOCK_SOURCE_SELECT;
      cap_code_q   <= {MASTER_RATIO_HI, MASTER_RATIO_LO};
      cap_master_q <= MASTER_SLAVE_SELECT;
      cap_ee_q     <= EEPROM_PORT_SELECT;
    end
  end

  rise_detect #(.INIT(1'b1)) u_hold_release (
    .clk    (REF_CLK),
    .rst    (RST),
    .level  (~hold_d),
    .rise_q (release_q)
  );

  rise_detect #(.INIT(1'b1)) u_sys_release (
    .clk    (REF_CLK),
    .rst    (RST),
    .level  (SYSTEM_RESET_N),
    .rise_q (sys_rise_q)
  );

  // controller state: held during clock reset, running after release
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_HELD;
    end else begin
      case (state_q)
        ST_HELD: if (release_q) state_q <= ST_RUN;
        ST_RUN:  if (hold_d) state_q <= ST_HELD;
        default: state_q <= ST_HELD;
      endcase
    end
  end

  assign CLOCKS_HELD = state_q[0];

  assign slave_bck_d = ~cap_src_q & ~cap_master_q;

  // pll setup applied once, at the release of the clock reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PLL_ENABLE   <= 1'b0;
      PLL_REF_SEL  <= REF_CRYSTAL;
      PLL_MULT_NUM <= `XT_NUM_0;
      PLL_MULT_DEN <= `XT_DEN_0;
      CONFIG_VALID <= 1'b0;
    end else if (state_q == ST_HELD && release_q) begin
      CONFIG_VALID <= cap_src_q | ~cap_master_q;
      if (cap_src_q) begin
        PLL_REF_SEL <= REF_CRYSTAL;
        PLL_ENABLE  <= (cap_code_q != 2'h3);
        case (cap_code_q)
          2'h0: begin PLL_MULT_NUM <= `XT_NUM_0; PLL_MULT_DEN <= `XT_DEN_0; end
          2'h1: begin PLL_MULT_NUM <= `XT_NUM_1; PLL_MULT_DEN <= `XT_DEN_1; end
          2'h2: begin PLL_MULT_NUM <= `XT_NUM_2; PLL_MULT_DEN <= `XT_DEN_2; end
          default: begin PLL_MULT_NUM <= `XT_NUM_3; PLL_MULT_DEN <= `XT_DEN_3; end
        endcase
      end else begin
        PLL_REF_SEL  <= cap_ee_q ? REF_BCK_PIN : REF_BCK_IN;
        PLL_ENABLE   <= ~cap_master_q;
        PLL_MULT_DEN <= 2'h1;
        case (cap_code_q)
          2'h0:    PLL_MULT_NUM <= `BK_NUM_0;
          2'h1:    PLL_MULT_NUM <= `BK_NUM_1;
          2'h2:    PLL_MULT_NUM <= `BK_NUM_2;
          default: PLL_MULT_NUM <= `BK_NUM_3;
        endcase
      end
    end
  end

  // effective sample mode; bit clock source in slave mode overrides the speed field
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SAMPLE_MODE <= `FS_MODE_STD;
    end else if (slave_bck_d) begin
      case (cap_code_q)
        2'h0:    SAMPLE_MODE <= `FS_MODE_STD;
        2'h1:    SAMPLE_MODE <= `FS_MODE_DBL;
        2'h2:    SAMPLE_MODE <= `FS_MODE_QUAD;
        default: SAMPLE_MODE <= `FS_MODE_8K;
      endcase
    end else begin
      SAMPLE_MODE <= rate_cfg_q[`SPEED_MSB:`SPEED_LSB];
    end
  end

  // slave clock pass-through on the dedicated pins, and the bit clock the pll takes
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BIT_CLOCK_OUT   <= 1'b0;
      FRAME_CLOCK_OUT <= 1'b0;
      sel_bck_q       <= 1'b0;
    end else begin
      sel_bck_q       <= slave_bck_d & (cap_ee_q ? BIT_CLOCK : BIT_CLOCK_IN);
      BIT_CLOCK_OUT   <= ~cap_master_q & ~cap_ee_q & clk_out_q[`BCK_OUT_EN_POS] & BIT_CLOCK_IN;
      FRAME_CLOCK_OUT <= ~cap_master_q & ~cap_ee_q & clk_out_q[`FRM_OUT_EN_POS] & FRAME_CLOCK_IN;
    end
  end

  // phase alignment pulse at system reset release in slave mode
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PHASE_ALIGN <= 1'b0;
    end else begin
      PHASE_ALIGN <= sys_rise_q & ~cap_master_q & ~CLOCKS_HELD;
    end
  end

  // power-save controls for the converters
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ADC_POWER_SAVE   <= 1'b0;
      CODEC_POWER_SAVE <= 1'b0;
    end else begin
      ADC_POWER_SAVE   <= power_q[`ADC_PS_POS];
      CODEC_POWER_SAVE <= power_q[`CODEC_PS_POS];
    end
  end

  // checks on the selector
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_release;
    state_q == ST_HELD && release_q;
  endsequence

  sequence s_run_steady;
    state_q == ST_RUN && !hold_d;
  endsequence

  AST_BIT_HOLDS: assert property (rate_cfg_q[`CLK_RST_BIT_POS] |-> ##[1:2] CLOCKS_HELD)
    else $error("clock reset bit did not hold the clocks");

  AST_XTAL_BYPASS: assert property (s_release ##0 (cap_src_q && cap_code_q == 2'h3)
      |=> !PLL_ENABLE && PLL_MULT_NUM == 7'h01)
    else $error("crystal code 3 did not bypass the pll");

  AST_XTAL_RATIO: assert property (s_release ##0 (cap_src_q && cap_code_q == 2'h2)
      |=> PLL_ENABLE && PLL_MULT_NUM == 7'h03 && PLL_MULT_DEN == 2'h2)
    else $error("crystal code 2 ratio wrong");

  AST_BCK_RATIO: assert property (s_release ##0 (!cap_src_q && cap_code_q == 2'h3)
      |=> PLL_MULT_NUM == 7'h48 && PLL_MULT_DEN == 2'h1)
    else $error("bit clock code 3 ratio wrong");

  AST_BCK_PORT: assert property (s_release ##0 !cap_src_q
      |=> PLL_REF_SEL == (cap_ee_q ? REF_BCK_PIN : REF_BCK_IN))
    else $error("bit clock port selection wrong");

  AST_STEADY: assert property (s_run_steady ##1 s_run_steady
      |-> $stable(PLL_MULT_NUM) && $stable(PLL_REF_SEL) && $stable(PLL_ENABLE))
    else $error("pll setup changed while running");

  AST_RATE_FIXED: assert property (slave_bck_d && $stable(cap_code_q) && cap_code_q == 2'h3
      |=> SAMPLE_MODE == 3'h7)
    else $error("bit clock code 3 did not force 8 kHz");

  AST_PASS: assert property (!cap_master_q && !cap_ee_q && clk_out_q[`BCK_OUT_EN_POS]
      && $stable(cap_master_q) |=> BIT_CLOCK_OUT == $past(BIT_CLOCK_IN))
    else $error("bit clock not forwarded");

  AST_ALIGN: assert property ($rose(SYSTEM_RESET_N) && !cap_master_q && !CLOCKS_HELD
      && $stable(CLOCKS_HELD) ##1 !CLOCKS_HELD |=> PHASE_ALIGN)
    else $error("no phase alignment after system reset release");

  AST_PIN_RESET: assert property (!CLOCK_RESET_PIN_N |-> ##[1:2] CLOCKS_HELD)
    else $error("clock reset pin did not hold the clocks");

endmodule // mclk_source_select

// [core/mclk_sel_params.svh]
// register offsets, field positions, reset values and ratio constants of the clock selector
`ifndef MCLK_SEL_PARAMS_SVH
`define MCLK_SEL_PARAMS_SVH

// register byte offsets
`define RATE_CFG_OFS      8'h00
`define POWER_CTRL_OFS    8'h04
`define CLOCK_OUT_OFS     8'h08
`define CLOCK_STATUS_OFS  8'h0C
`define MCLK_NOMINAL_OFS  8'h10

// rate_config_register fields
`define SPEED_MSB         7
`define SPEED_LSB         5
`define IFMT_MSB          4
`define IFMT_LSB          2
`define CLK_RST_BIT_POS   1
// power control fields
`define ADC_PS_POS        0
`define CODEC_PS_POS      1
// clock output control fields
`define BCK_OUT_EN_POS    0
`define FRM_OUT_EN_POS    1
`define FAMILY_44K_POS    4

// reset values
`define RATE_CFG_RST      8'h00
`define POWER_CTRL_RST    2'h0
`define CLOCK_OUT_RST     3'h0

// nominal master clock, 36.864 MHz and 33.8688 MHz, in Hz
`define MCLK_NOM_48K_HZ   32'h0232_8000
`define MCLK_NOM_44K_HZ   32'h0204_CC00

// pll multiply ratios, crystal source, codes 0..3
`define XT_NUM_0          7'h03
`define XT_DEN_0          2'h1
`define XT_NUM_1          7'h02
`define XT_DEN_1          2'h1
`define XT_NUM_2          7'h03
`define XT_DEN_2          2'h2
`define XT_NUM_3          7'h01
`define XT_DEN_3          2'h1
// pll multiply ratios, bit clock source, codes 0..3
`define BK_NUM_0          7'h0C
`define BK_NUM_1          7'h06
`define BK_NUM_2          7'h03
`define BK_NUM_3          7'h48

// sample mode codes forced by the bit clock ratio
`define FS_MODE_STD       3'h0
`define FS_MODE_DBL       3'h1
`define FS_MODE_QUAD      3'h2
`define FS_MODE_8K        3'h7

`endif

// [core/mclk_sel_pkg.sv]
// types shared by the master clock source selector
package mclk_sel_pkg;

  // reference feeding the pll
  typedef enum logic [1:0] {
    REF_CRYSTAL  = 2'h0,
    REF_BCK_IN   = 2'h1,
    REF_BCK_PIN  = 2'h2
  } ref_sel_t;

  // clock controller states
  typedef enum logic [1:0] {
    ST_HELD = 2'b01,
    ST_RUN  = 2'b10
  } ctl_state_t;

endpackage

// [core/rise_detect.sv]
// registered rising-edge detector for a synchronous level
`timescale 1ns/1ps
module rise_detect #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,    // reference clock
  input  wire logic rst,    // async reset, high
  input  wire logic level,  // level to watch
  output logic      rise_q  // one-cycle pulse after a low-to-high step
);

  logic last_q;

  // remember previous level and flag the step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= INIT;
      rise_q <= 1'b0;
    end else begin
      last_q <= level;
      rise_q <= level & ~last_q;
    end
  end

endmodule // rise_detect

// [tb/audio_clk_src.sv]
// behavioural external audio clock master feeding the slave clock inputs
`timescale 1ns/1ps
module audio_clk_src (
  input  wire logic clk,       // reference clock
  input  wire logic rst,       // async reset, high
  input  wire logic run,       // clocks run while high
  output logic      frame_clk, // 1fs frame clock
  output logic      bit_clk,   // 64fs bit clock on the dedicated pin
  output logic      bit_pin    // 64fs bit clock on the shared pin
);
  logic [6:0] cnt_q;

  // one counter gives 64 bit clocks per frame, so both stay frequency locked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 7'h00;
    end else if (!run) begin
      cnt_q <= 7'h00; // clocks stand still while the source is idle
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // bit clock toggles every reference cycle, frame clock every 64
  assign bit_clk   = cnt_q[0];
  assign bit_pin   = cnt_q[0];
  assign frame_clk = cnt_q[6];
endmodule // audio_clk_src

// [tb/master_clock_source_select_bench.sv]
// self-checking bench for the master clock source selector
`timescale 1ns/1ps
module master_clock_source_select_bench;
  import mclk_sel_pkg::*;
  logic                   ref_clk, rst, psel, penable, pwrite, run, er, pb, pf;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd, pulses;
  logic                   pready, pslverr, cks, rhi, rlo, mss, ees, init_n, sys_n, ckr_n;
  logic                   frm_in, bck_in, bck_pin, frm_out, bck_out, held, pll_en;
  logic                   cvalid, palign, adc_ps, cod_ps;
  mclk_sel_pkg::ref_sel_t ref_sel;
  logic [6:0]             num;
  logic [1:0]             den;
  logic [2:0]             master_slave_select;
  int                     err_count, compares;

  // 20 MHz reference clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  mclk_source_select #(.ADDR_W(8)) u_dut (
    .REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CLOCK_SOURCE_SELECT(cks), .MASTER_RATIO_HI(rhi), .MASTER_RATIO_LO(rlo),
    .MASTER_SLAVE_SELECT(mss), .EEPROM_PORT_SELECT(ees), .INITIAL_RESET_N(init_n),
    .SYSTEM_RESET_N(sys_n), .CLOCK_RESET_PIN_N(ckr_n), .FRAME_CLOCK_IN(frm_in),
    .BIT_CLOCK_IN(bck_in), .BIT_CLOCK(bck_pin), .FRAME_CLOCK_OUT(frm_out),
    .BIT_CLOCK_OUT(bck_out), .CLOCKS_HELD(held), .PLL_ENABLE(pll_en),
    .PLL_REF_SEL(ref_sel), .PLL_MULT_NUM(num), .PLL_MULT_DEN(den), .SAMPLE_MODE(master_slave_select),
    .CONFIG_VALID(cvalid), .PHASE_ALIGN(palign), .ADC_POWER_SAVE(adc_ps),
    .CODEC_POWER_SAVE(cod_ps)
  );

  audio_clk_src u_src (
    .clk(ref_clk), .rst(rst), .run(run), .frame_clk(frm_in), .bit_clk(bck_in),
    .bit_pin(bck_pin)
  );

  // value compare, counts every check
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait for the clock hold flag
  task automatic wait_held(input logic want);
    int n;
    n = 0;
    while (held !== want && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    chk("clock hold wait", {31'h0, want}, {31'h0, held});
    if (held !== want) complete_run();
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb ready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1) complete_run();
  endtask

  // reselect clock pins under clock reset and check the captured setup
  task automatic reselect(input logic src, input logic [1:0] code, input logic ms,
                          input logic ee);
    logic [6:0] xn;
    logic [2:0] xm;
    case (code)
      2'h0: begin xn = src ? 7'h03 : 7'h0C; xm = 3'h0; end
      2'h1: begin xn = src ? 7'h02 : 7'h06; xm = 3'h1; end
      2'h2: begin xn = src ? 7'h03 : 7'h03; xm = 3'h2; end
      default: begin xn = src ? 7'h01 : 7'h48; xm = 3'h7; end
    endcase
    if (src || ms) xm = 3'h3; // speed field written below
    @(posedge ref_clk);
    sys_n <= 1'b0;
    ckr_n <= 1'b0;
    wait_held(1'b1);
    @(posedge ref_clk);
    cks <= src;
    rhi <= code[1];
    rlo <= code[0];
    mss <= ms;
    ees <= ee;
    apb(1'b1, 8'h04, {30'h0, {2{!src && (code == 2'h1 || code == 2'h2)}}});
    apb(1'b1, 8'h00, 32'h0000_0060);
    @(posedge ref_clk);
    ckr_n <= 1'b1;
    wait_held(1'b0);
    chk("config valid", {31'h0, src | !ms}, {31'h0, cvalid});
    chk("pll enable", {31'h0, (src | !ms) & !(src & code == 2'h3)}, {31'h0, pll_en});
    if (src | !ms) begin
      chk("mult num", {25'h0, xn}, {25'h0, num});
      chk("mult den", {30'h0, (src && code == 2'h2) ? 2'h2 : 2'h1}, {30'h0, den});
      chk("pll ref", {30'h0, src ? 2'h0 : (ee ? 2'h2 : 2'h1)}, {30'h0, ref_sel});
      chk("sample mode", {29'h0, xm}, {29'h0, master_slave_select});
    end
    @(posedge ref_clk);
    sys_n <= 1'b1;
    pulses = 32'h0;
    repeat (6) begin
      @(negedge ref_clk);
      pulses = pulses + {31'h0, palign};
    end
    chk("phase align pulses", {31'h0, !ms}, pulses);
  endtask

  // reset state and default crystal code 0
  task automatic test_reset();
    chk("held at reset", 32'h1, {31'h0, held});
    chk("num at reset", 32'h3, {25'h0, num});
    chk("den at reset", 32'h1, {30'h0, den});
    @(posedge ref_clk);
    init_n <= 1'b1;
    run <= 1'b1;
    wait_held(1'b0);
    chk("default num", 32'h3, {25'h0, num});
    chk("default pll", 32'h1, {31'h0, pll_en});
    $display("test reset done");
  endtask

  // every ratio code for every source
  task automatic test_select();
    // crystal_in counts as a fed clock in every code
    for (int c = 0; c < 4; c++) begin
      reselect(1'b1, c[1:0], 1'b0, 1'b0);
      reselect(1'b0, c[1:0], 1'b0, 1'b0);
      reselect(1'b0, c[1:0], 1'b0, 1'b1);
    end
    reselect(1'b0, 2'h0, 1'b1, 1'b0);
    reselect(1'b1, 2'h1, 1'b1, 1'b1);
    $display("test select done");
  endtask

  // pin changes outside a hold, then refused write and register clock reset
  task automatic test_hold();
    reselect(1'b1, 2'h1, 1'b0, 1'b0);
    @(posedge ref_clk);
    rhi <= 1'b1;
    cks <= 1'b0;
    repeat (5) @(negedge ref_clk);
    chk("num after stray pins", 32'h2, {25'h0, num});
    apb(1'b1, 8'h00, 32'h0000_0002);
    chk("refused write err", 32'h1, {31'h0, er});
    repeat (3) @(negedge ref_clk);
    chk("held after refusal", 32'h0, {31'h0, held});
    @(posedge ref_clk);
    sys_n <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0002);
    wait_held(1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk("rate cfg readback", 32'h2, rd);
    @(posedge ref_clk);
    cks <= 1'b1;
    rhi <= 1'b0;
    rlo <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("num while held", 32'h2, {25'h0, num});
    apb(1'b1, 8'h00, 32'h0000_0000);
    wait_held(1'b0);
    chk("num after bit release", 32'h3, {25'h0, num});
    $display("test hold done");
  endtask

  // power bits, nominal master clock, unmapped offset
  task automatic test_regs();
    apb(1'b1, 8'h04, 32'h0000_0003);
    chk("power write err", 32'h0, {31'h0, er});
    apb(1'b0, 8'h04, 32'h0);
    chk("power readback", 32'h3, rd);
    chk("power outputs", 32'h3, {30'h0, cod_ps, adc_ps});
    apb(1'b0, 8'h10, 32'h0);
    chk("nominal 48k", 32'h0232_8000, rd);
    apb(1'b1, 8'h08, 32'h0000_0010);
    apb(1'b0, 8'h10, 32'h0);
    chk("nominal 44k", 32'h0204_CC00, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 8'h0C, 32'h0);
    chk("status word", 32'h0000_0142, rd);
    $display("test regs done");
  endtask

  // forwarded clocks follow the inputs one cycle late when enabled
  task automatic pass_chk(input logic [1:0] en);
    repeat (2) @(negedge ref_clk);
    pb = bck_in;
    pf = frm_in;
    repeat (130) begin
      @(negedge ref_clk);
      chk("bit clock out", {31'h0, en[0] & pb}, {31'h0, bck_out});
      chk("frame clock out", {31'h0, en[1] & pf}, {31'h0, frm_out});
      pb = bck_in;
      pf = frm_in;
    end
  endtask

  // slave pass-through with bit clock only, both, then neither enabled
  task automatic test_pass();
    reselect(1'b1, 2'h0, 1'b0, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    pass_chk(2'b01);
    apb(1'b1, 8'h08, 32'h0000_0003);
    pass_chk(2'b11);
    apb(1'b1, 8'h08, 32'h0000_0000);
    pass_chk(2'b00);
    $display("test pass done");
  endtask

  // main sequence
  initial begin
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {psel, penable, pwrite, run, cks, rhi, rlo, mss, ees} = 9'h010; // crystal, open ratio pins
    paddr = 8'h00;
    pwdata = 32'h0;
    init_n = 1'b0;
    sys_n = 1'b0;
    ckr_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    test_reset();
    test_select();
    test_hold();
    test_regs();
    test_pass();
    complete_run();
  end
endmodule // master_clock_source_select_bench
